// ===== verilog/sps_pkg.sv
// Shared types and constants for the stored-program flow sequencer
package sps_pkg;
   localparam int ADDR_W = 16;
   localparam int SEL_W  = 3;

   // Decoded opcodes of one stored instruction, as the fetch port delivers them
   typedef enum logic [2:0] {
      SPS_OP_END    = 3'b000,
      SPS_OP_MOTION = 3'b001,
      SPS_OP_WAITM  = 3'b010,
      SPS_OP_CALL   = 3'b011,
      SPS_OP_RET    = 3'b100,
      SPS_OP_LINE   = 3'b101,
      SPS_OP_SWITCH = 3'b110,
      SPS_OP_OTHER  = 3'b111
   } sps_op_t;

   typedef enum logic [1:0] {
      SPS_CMD_NONE  = 2'b00,
      SPS_CMD_ABORT = 2'b01,
      SPS_CMD_DUMP  = 2'b10,
      SPS_CMD_RUN   = 2'b11
   } sps_kind_t;

   typedef struct packed {
      sps_kind_t           kind;
      logic [ADDR_W-1:0]   addr;
   } sps_cmd_t;

   typedef struct packed {
      sps_op_t             op;
      logic [SEL_W-1:0]    line_sel;
      logic                level;
      logic                sw_invert;
      logic                sw_hex;
      logic                sw_two;
      logic [7:0]          cmp;
      logic [ADDR_W-1:0]   tgt_match;
      logic [ADDR_W-1:0]   tgt_miss;
      logic [ADDR_W-1:0]   next_pc;
   } sps_ins_t;

   localparam logic [7:0]        SPS_CH_END    = 8'h00;
   localparam logic [7:0]        SPS_CH_CR     = 8'h0D;
   localparam logic [7:0]        SPS_CH_COLON  = 8'h3A;
   localparam logic [7:0]        SPS_CH_DONE   = 8'h63;
   localparam logic [7:0]        SPS_CH_ZERO   = 8'h30;
   localparam logic [7:0]        SPS_CH_ALPHA  = 8'h37;
   localparam logic [3:0]        SPS_DEC_MAX   = 4'h9;
   localparam logic [1:0]        SPS_HEX_LAST  = 2'h3;
   localparam logic [ADDR_W-1:0] SPS_TGT_NEXT  = 16'h0000;
   localparam logic [ADDR_W-1:0] SPS_ADDR_ONE  = 16'h0001;
endpackage : sps_pkg

// ===== verilog/sps_flow_seq.sv
// Flow-control sequencer: abort, memory listing, branches, motion wait, one-level calls
//
// Overview of operation
// - Abort stops motor and halts program
// - Listing sends memory from address until zero
// - Each entry: address, colon, instruction text
// - Listing ends with lowercase c
// - Line test compares input with level code
// - Match goes to match address, else mismatch
// - Branch target zero means next instruction
// - Motion wait holds until motion complete
// - Motion commands queue without waiting otherwise
// - Call saves following location, jumps to start
// - Return resumes after most recent call
// - Only one subroutine level; no nesting
// - Invert option flips every switch bit
// - Base sixteen takes 0-F, decimal 0-9
// - One-digit variants treat two digits as one
// - Switch value equal jumps match, else mismatch
// - Execution runs until a zero instruction
`timescale 1ns/1ps
`default_nettype none

module sps_flow_seq
   import sps_pkg::*;
#(
   parameter int N_IN      = 8,
   parameter bit ONE_DIGIT = 1'b0
) (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                cmd_valid,
   input  wire sps_cmd_t            cmd,
   output logic                     cmd_ready,
   output logic                     tx_valid,
   output logic [7:0]               tx_data,
   input  wire logic                tx_ready,
   output logic                     rd_req,
   output logic [ADDR_W-1:0]        rd_addr,
   input  wire logic                rd_ack,
   input  wire logic [7:0]          rd_data,
   output logic                     fetch_req,
   output logic [ADDR_W-1:0]        fetch_addr,
   input  wire logic                fetch_ack,
   input  wire sps_ins_t            fetch_ins,
   output logic                     mot_cmd_valid,
   output logic [ADDR_W-1:0]        mot_cmd_addr,
   input  wire logic                mot_cmd_ready,
   input  wire logic                motion_busy,
   output logic                     motor_stop,
   input  wire logic [N_IN-1:0]     in_lines,
   input  wire logic [7:0]          sw_pins,
   output logic                     running,
   output logic                     in_sub,
   output logic                     nest_err,
   output logic                     dump_busy
);

   generate
      if (N_IN < 1 || N_IN > (1 << SEL_W)) begin : g_bad_nin
         $error("N_IN must lie between 1 and 2**SEL_W");
      end
   endgenerate

   function automatic logic [7:0] hex_ascii(input logic [3:0] nib);
      hex_ascii = (nib > SPS_DEC_MAX) ? SPS_CH_ALPHA + {4'h0, nib} : SPS_CH_ZERO + {4'h0, nib};
   endfunction : hex_ascii

   function automatic logic [ADDR_W-1:0] pick(input logic [ADDR_W-1:0] tgt,
                                               input logic [ADDR_W-1:0] nxt);
      pick = (tgt == SPS_TGT_NEXT) ? nxt : tgt;
   endfunction : pick

   // Pin inputs pass two flops; only the second stage is read by logic
   logic [N_IN+7:0] sync_a;
   logic [N_IN+7:0] sync_b;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {sw_pins, in_lines};
         sync_b <= sync_a;
      end
   end
   logic [N_IN-1:0] lines_s;
   logic [7:0]      sw_s;
   assign lines_s = sync_b[N_IN-1:0];
   assign sw_s    = sync_b[N_IN+7:N_IN];

   logic abort_cmd;
   logic dump_cmd;
   logic run_cmd;
   assign abort_cmd = cmd_valid && cmd.kind == SPS_CMD_ABORT;
   assign dump_cmd  = cmd_valid && cmd_ready && cmd.kind == SPS_CMD_DUMP;
   assign run_cmd   = cmd_valid && cmd_ready && cmd.kind == SPS_CMD_RUN;

   // Two-entry output buffer: head drives the port, spare catches the word
   // pushed in the cycle the receiver stalls, so no listing byte is dropped
   logic       push;
   logic [7:0] push_data;
   logic       spare_valid;
   logic [7:0] spare_data;
   logic       buf_ready;
   assign buf_ready = !spare_valid;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_valid    <= 1'b0;
         tx_data     <= 8'h00;
         spare_valid <= 1'b0;
         spare_data  <= 8'h00;
      end else begin
         if (!tx_valid || tx_ready) begin
            tx_valid <= spare_valid || push;
            tx_data  <= spare_valid ? spare_data : push_data;
            if (spare_valid) begin
               spare_valid <= push;
               spare_data  <= push_data;
            end
         end else if (push) begin
            spare_valid <= 1'b1;
            spare_data  <= push_data;
         end
      end
   end

   // Memory listing
   typedef enum logic [2:0] {
      DS_IDLE  = 3'b000,
      DS_FETCH = 3'b001,
      DS_WAIT  = 3'b010,
      DS_HEAD  = 3'b011,
      DS_COLON = 3'b100,
      DS_TEXT  = 3'b101,
      DS_DONE  = 3'b110
   } sps_dstate_t;

   sps_dstate_t dstate;
   logic [7:0]  dbyte;
   logic        entry_start;
   logic [1:0]  hex_idx;
   logic [3:0]  cur_nib;

   always_comb begin
      case (hex_idx)
         2'd0:    cur_nib = rd_addr[15:12];
         2'd1:    cur_nib = rd_addr[11:8];
         2'd2:    cur_nib = rd_addr[7:4];
         default: cur_nib = rd_addr[3:0];
      endcase
   end

   always_comb begin
      push      = 1'b0;
      push_data = 8'h00;
      if (buf_ready) begin
         case (dstate)
            DS_HEAD: begin
               push      = (dbyte != SPS_CH_END);
               push_data = hex_ascii(cur_nib);
            end
            DS_COLON: begin
               push      = 1'b1;
               push_data = SPS_CH_COLON;
            end
            DS_TEXT: begin
               // The closing zero byte ends the listing and is never sent
               push      = (dbyte != SPS_CH_END);
               push_data = dbyte;
            end
            DS_DONE: begin
               push      = 1'b1;
               push_data = SPS_CH_DONE;
            end
            default: begin
               push      = 1'b0;
               push_data = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dstate      <= DS_IDLE;
         rd_req      <= 1'b0;
         rd_addr     <= '0;
         dbyte       <= 8'h00;
         entry_start <= 1'b0;
         hex_idx     <= 2'd0;
      end else begin
         rd_req <= 1'b0;
         case (dstate)
            DS_IDLE: begin
               if (dump_cmd) begin
                  rd_addr     <= cmd.addr;
                  entry_start <= 1'b1;
                  dstate      <= DS_FETCH;
               end
            end
            DS_FETCH: begin
               rd_req <= 1'b1;
               dstate <= DS_WAIT;
            end
            DS_WAIT: begin
               if (rd_ack) begin
                  dbyte   <= rd_data;
                  hex_idx <= 2'd0;
                  dstate  <= entry_start ? DS_HEAD : DS_TEXT;
               end
            end
            DS_HEAD: begin
               if (dbyte == SPS_CH_END) begin
                  dstate <= DS_DONE;
               end else if (buf_ready) begin
                  hex_idx <= hex_idx + 2'd1;
                  if (hex_idx == SPS_HEX_LAST) begin
                     dstate <= DS_COLON;
                  end
               end
            end
            DS_COLON: begin
               if (buf_ready) begin
                  dstate <= DS_TEXT;
               end
            end
            DS_TEXT: begin
               if (dbyte == SPS_CH_END) begin
                  dstate <= DS_DONE;
               end else if (buf_ready) begin
                  rd_addr     <= rd_addr + SPS_ADDR_ONE;
                  entry_start <= (dbyte == SPS_CH_CR);
                  dstate      <= DS_FETCH;
               end
            end
            DS_DONE: begin
               if (buf_ready) begin
                  dstate <= DS_IDLE;
               end
            end
            default: dstate <= DS_IDLE;
         endcase
      end
   end

   // Program execution
   typedef enum logic [2:0] {
      ES_IDLE  = 3'b000,
      ES_FETCH = 3'b001,
      ES_WAIT  = 3'b010,
      ES_EXEC  = 3'b011,
      ES_MWAIT = 3'b100
   } sps_estate_t;

   sps_estate_t       estate;
   sps_ins_t          ins;
   logic [ADDR_W-1:0] ret_pc;
   logic              line_hit;
   logic [7:0]        sw_cond;
   logic [7:0]        sw_val;
   logic              sw_legal;
   logic              sw_hit;

   assign line_hit = (lines_s[ins.line_sel] == ins.level);
   assign sw_cond  = ins.sw_invert ? ~sw_s : sw_s;
   // Two-digit reading only where the hardware wires both digits
   assign sw_val   = (ins.sw_two && !ONE_DIGIT) ? sw_cond : {4'h0, sw_cond[3:0]};
   assign sw_legal = ins.sw_hex ||
                     (sw_val[3:0] <= SPS_DEC_MAX && sw_val[7:4] <= SPS_DEC_MAX);
   assign sw_hit   = sw_legal && (sw_val == ins.cmp);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         estate        <= ES_IDLE;
         fetch_req     <= 1'b0;
         fetch_addr    <= '0;
         ins           <= '0;
         ret_pc        <= '0;
         in_sub        <= 1'b0;
         nest_err      <= 1'b0;
         mot_cmd_valid <= 1'b0;
         mot_cmd_addr  <= '0;
      end else begin
         fetch_req     <= 1'b0;
         mot_cmd_valid <= 1'b0;
         if (abort_cmd) begin
            estate <= ES_IDLE;
            in_sub <= 1'b0;
         end else begin
            case (estate)
               ES_IDLE: begin
                  if (run_cmd) begin
                     fetch_addr <= cmd.addr;
                     in_sub     <= 1'b0;
                     nest_err   <= 1'b0;
                     estate     <= ES_FETCH;
                  end
               end
               ES_FETCH: begin
                  fetch_req <= 1'b1;
                  estate    <= ES_WAIT;
               end
               ES_WAIT: begin
                  if (fetch_ack) begin
                     ins    <= fetch_ins;
                     estate <= ES_EXEC;
                  end
               end
               ES_EXEC: begin
                  estate     <= ES_FETCH;
                  fetch_addr <= ins.next_pc;
                  case (ins.op)
                     SPS_OP_END: estate <= ES_IDLE;
                     SPS_OP_MOTION: begin
                        // Stay until the engine's queue takes the command
                        if (mot_cmd_ready) begin
                           mot_cmd_valid <= 1'b1;
                           mot_cmd_addr  <= fetch_addr;
                        end else begin
                           // Keep this instruction's address for the queued command
                           fetch_addr <= fetch_addr;
                           estate     <= ES_EXEC;
                        end
                     end
                     SPS_OP_WAITM: estate <= ES_MWAIT;
                     SPS_OP_CALL: begin
                        ret_pc     <= ins.next_pc;
                        fetch_addr <= ins.tgt_match;
                        in_sub     <= 1'b1;
                        if (in_sub) begin
                           nest_err <= 1'b1;
                        end
                     end
                     SPS_OP_RET: begin
                        if (in_sub) begin
                           fetch_addr <= ret_pc;
                           in_sub     <= 1'b0;
                        end
                     end
                     SPS_OP_LINE: begin
                        fetch_addr <= line_hit ? pick(ins.tgt_match, ins.next_pc)
                                               : pick(ins.tgt_miss, ins.next_pc);
                     end
                     SPS_OP_SWITCH: begin
                        fetch_addr <= sw_hit ? pick(ins.tgt_match, ins.next_pc)
                                             : pick(ins.tgt_miss, ins.next_pc);
                     end
                     default: fetch_addr <= ins.next_pc;
                  endcase
               end
               ES_MWAIT: begin
                  // Busy from the engine is same-clock, so it is read directly
                  if (!motion_busy) begin
                     estate <= ES_FETCH;
                  end
               end
               default: estate <= ES_IDLE;
            endcase
         end
      end
   end

   // Status and stop pulse
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         motor_stop <= 1'b0;
         running    <= 1'b0;
         dump_busy  <= 1'b0;
         cmd_ready  <= 1'b0;
      end else begin
         motor_stop <= abort_cmd;
         running    <= (estate != ES_IDLE) && !abort_cmd;
         dump_busy  <= (dstate != DS_IDLE) || dump_cmd;
         cmd_ready  <= (estate == ES_IDLE) && (dstate == DS_IDLE) && !run_cmd && !dump_cmd;
      end
   end

endmodule : sps_flow_seq

`default_nettype wire

// ===== tb/sps_flow_seq_chk.sv
// Port-level assertions for the flow sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_flow_seq_chk
   import sps_pkg::*;
#(
   parameter int N_IN      = 8,
   parameter bit ONE_DIGIT = 1'b0
) (
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic              cmd_valid,
   input wire sps_cmd_t          cmd,
   input wire logic              cmd_ready,
   input wire logic              tx_valid,
   input wire logic [7:0]        tx_data,
   input wire logic              tx_ready,
   input wire logic              rd_req,
   input wire logic [ADDR_W-1:0] rd_addr,
   input wire logic              fetch_req,
   input wire logic [ADDR_W-1:0] fetch_addr,
   input wire logic              fetch_ack,
   input wire sps_ins_t          fetch_ins,
   input wire logic              motion_busy,
   input wire logic              motor_stop,
   input wire logic [N_IN-1:0]   in_lines,
   input wire logic [7:0]        sw_pins,
   input wire logic              running,
   input wire logic              in_sub,
   input wire logic              nest_err
);
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic              wait_m;
   logic [ADDR_W-1:0] ret_a;
   logic [ADDR_W-1:0] exp_pc;
   logic [ADDR_W-1:0] t;
   logic [7:0]        sv;
   logic              hit;

   // Pins are held steady around a branch, so raw pins stand for their synchronised copies
   always_comb begin
      sv = fetch_ins.sw_invert ? ~sw_pins : sw_pins;
      if (!fetch_ins.sw_two || ONE_DIGIT) sv[7:4] = 4'h0;
      hit = sv == fetch_ins.cmp;
      if (!fetch_ins.sw_hex && (sv[3:0] > SPS_DEC_MAX || sv[7:4] > SPS_DEC_MAX)) hit = 1'b0;
      if (fetch_ins.op == SPS_OP_LINE) hit = in_lines[fetch_ins.line_sel] == fetch_ins.level;
      t = hit ? fetch_ins.tgt_match : fetch_ins.tgt_miss;
      exp_pc = (t == SPS_TGT_NEXT) ? fetch_ins.next_pc : t;
      if (fetch_ins.op == SPS_OP_CALL) exp_pc = fetch_ins.tgt_match;
      if (fetch_ins.op == SPS_OP_RET) exp_pc = in_sub ? ret_a : fetch_ins.next_pc;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wait_m <= 1'b0;
         ret_a  <= '0;
      end else begin
         if (fetch_ack && fetch_ins.op == SPS_OP_CALL) ret_a <= fetch_ins.next_pc;
         if (fetch_ack) wait_m <= fetch_ins.op == SPS_OP_WAITM;
         else if (fetch_req || !running) wait_m <= 1'b0;
      end
   end

   sequence s_ack(sps_op_t o);
      fetch_ack && fetch_ins.op == o;
   endsequence
   sequence s_take(sps_kind_t k);
      cmd_valid && cmd_ready && cmd.kind == k;
   endsequence
   property p_goes(sps_op_t o);
      s_ack(o) |-> ##3 fetch_req && fetch_addr == $past(exp_pc, 3);
   endproperty

   chk_abort_stop: assert property (
      cmd_valid && cmd.kind == SPS_CMD_ABORT |=> motor_stop && !running)
      else $error("abort did not stop motor and program");
   chk_run_fetch: assert property (
      s_take(SPS_CMD_RUN) |-> ##2 fetch_req && fetch_addr == $past(cmd.addr, 2))
      else $error("run did not fetch from its start address");
   chk_dump_read: assert property (
      s_take(SPS_CMD_DUMP) |-> ##2 rd_req && rd_addr == $past(cmd.addr, 2))
      else $error("listing did not read from its start address");
   chk_list_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("listing byte dropped during stall");
   chk_line_jump: assert property (p_goes(SPS_OP_LINE))
      else $error("line test went to wrong address");
   chk_switch_jump: assert property (p_goes(SPS_OP_SWITCH))
      else $error("switch test went to wrong address");
   chk_call_jump: assert property (p_goes(SPS_OP_CALL))
      else $error("call went to wrong address");
   chk_ret_back: assert property (p_goes(SPS_OP_RET))
      else $error("return went to wrong address");
   chk_nest_flag: assert property (
      s_ack(SPS_OP_CALL) ##0 in_sub |-> ##2 nest_err)
      else $error("nested call not flagged");
   chk_wait_motion: assert property (
      wait_m && motion_busy |=> !fetch_req)
      else $error("motion wait passed while motion busy");
endmodule : sps_flow_seq_chk

bind sps_flow_seq sps_flow_seq_chk #(.N_IN(N_IN), .ONE_DIGIT(ONE_DIGIT)) u_chk (.*);
`default_nettype wire

// ===== tb/sps_far_model.sv
// Far-side model: listing memory, instruction store and motion engine
`timescale 1ns/1ps
`default_nettype none
module sps_far_model
   import sps_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              rd_req,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic                   rd_ack,
   output logic [7:0]             rd_data,
   input  wire logic              fetch_req,
   input  wire logic [ADDR_W-1:0] fetch_addr,
   output logic                   fetch_ack,
   output sps_ins_t               fetch_ins,
   input  wire logic              mot_cmd_valid,
   output logic                   mot_cmd_ready,
   output logic                   motion_busy
);
   logic [7:0]        mem [256];
   sps_ins_t          prog [64];
   int                lat = 0;
   int                mot_len = 6;
   int                r_cnt;
   int                f_cnt;
   int                m_cnt;
   logic [ADDR_W-1:0] r_a;
   logic [ADDR_W-1:0] f_a;

   initial foreach (mem[i]) mem[i] = 8'h00;
   assign mot_cmd_ready = 1'b1;
   // Busy rises in the cycle a command is queued, so a wait cannot slip past it
   assign motion_busy = mot_cmd_valid || m_cnt != 0;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r_cnt <= 0;
         f_cnt <= 0;
         m_cnt <= 0;
         rd_ack <= 1'b0;
         fetch_ack <= 1'b0;
         rd_data <= 8'h00;
         fetch_ins <= '0;
      end else begin
         rd_ack <= r_cnt == 1;
         fetch_ack <= f_cnt == 1;
         // Released data toggles every cycle instead of keeping the last value
         rd_data <= (r_cnt == 1) ? mem[r_a[7:0]] : ~rd_data;
         fetch_ins <= (f_cnt == 1) ? prog[f_a[5:0]] : ~fetch_ins;
         r_cnt <= rd_req ? lat + 1 : (r_cnt != 0 ? r_cnt - 1 : 0);
         f_cnt <= fetch_req ? lat + 1 : (f_cnt != 0 ? f_cnt - 1 : 0);
         m_cnt <= mot_cmd_valid ? mot_len : (m_cnt != 0 ? m_cnt - 1 : 0);
         if (rd_req) r_a <= rd_addr;
         if (fetch_req) f_a <= fetch_addr;
      end
   end
endmodule : sps_far_model
`default_nettype wire

// ===== tb/test_stored_program_flow_sequencer.sv
// Self-checking bench for the stored-program flow sequencer
`timescale 1ns/1ps
`default_nettype none
module test_stored_program_flow_sequencer
   import sps_pkg::*;
();
   logic              clk_sys = 1'b0;
   logic              rst_n = 1'b0;
   logic              cmd_valid = 1'b0;
   sps_cmd_t          cmd = '0;
   logic              tx_ready = 1'b0;
   logic [7:0]        in_lines = 8'h04;
   logic [7:0]        sw_pins = 8'h37;
   logic              cmd_ready, tx_valid, rd_req, rd_ack, fetch_req, fetch_ack;
   logic              mot_cmd_valid, mot_cmd_ready, motion_busy, motor_stop;
   logic              running, in_sub, nest_err, dump_busy;
   logic [7:0]        tx_data, rd_data;
   logic [ADDR_W-1:0] rd_addr, fetch_addr, mot_cmd_addr;
   sps_ins_t          fetch_ins;
   logic              hold = 1'b1;
   int                failures = 0;
   int                n_compared = 0;
   int                cyc = 0;
   logic [7:0]        exp_tx [$];
   logic [15:0]       exp_fa [$];
   logic [15:0]       exp_ma [$];

   always #5 clk_sys = ~clk_sys;

   sps_flow_seq  uut (.*);
   sps_far_model far (.*);

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n > 4'h9) ? SPS_CH_ALPHA + 8'(n) : SPS_CH_ZERO + 8'(n);
   endfunction : hexc

   task automatic idle;
      // Let the taking edge settle first, or a stale ready ends the wait at once
      @(negedge clk_sys);
      for (int i = 0; i < 4000 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
   endtask : idle

   task automatic send(input sps_kind_t k, input logic [15:0] a, input logic w);
      @(negedge clk_sys);
      if (w) idle();
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd <= '{k, a};
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
   endtask : send

   // Flags: line select, level, invert, hex base, two digits
   task automatic put(input int i, input sps_op_t o, input logic [6:0] f, input logic [7:0] c,
                      input int m, input int x);
      far.prog[i] = {o, f, c, 16'(m), 16'(x), 16'(i + 1)};
   endtask : put

   always @(posedge clk_sys) tx_ready <= !hold && $urandom_range(0, 3) != 0;

   always @(posedge clk_sys) begin
      if (rst_n && tx_valid && tx_ready) check(16'(tx_data), exp_tx.size() ? exp_tx.pop_front() : 'x);
      if (rst_n && fetch_req) check(fetch_addr, exp_fa.size() ? exp_fa.pop_front() : 'x);
      if (rst_n && mot_cmd_valid) check(mot_cmd_addr, exp_ma.size() ? exp_ma.pop_front() : 'x);
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end

   initial begin
      logic [15:0] ad;
      logic [7:0]  ch;
      int          n;
      void'($urandom(32'h0029BEBF));
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Listing starts against a stalled receiver, so the buffer fills and refuses
      ad = 16'h0012;
      for (int e = 0; e < 4; e++) begin
         for (int b = 3; b >= 0; b--) exp_tx.push_back(hexc(ad[4*b +: 4]));
         exp_tx.push_back(SPS_CH_COLON);
         n = $urandom_range(1, 3);
         for (int b = 0; b <= n; b++) begin
            ch = (b < n) ? 8'h41 + 8'($urandom_range(0, 25)) : (e == 3 ? SPS_CH_END : SPS_CH_CR);
            far.mem[ad[7:0]] = ch;
            if (ch != SPS_CH_END) exp_tx.push_back(ch);
            ad++;
         end
      end
      exp_tx.push_back(SPS_CH_DONE);
      send(SPS_CMD_DUMP, 16'h0012, 1'b1);
      repeat (15) @(negedge clk_sys);
      check(dump_busy, 1'b1);
      hold = 1'b0;
      exp_tx.push_back(SPS_CH_DONE);
      send(SPS_CMD_DUMP, 16'h0080, 1'b1);
      idle();
      repeat (20) @(negedge clk_sys);
      check(16'(exp_tx.size()), 16'h0000);
      check(dump_busy, 1'b0);
      put(1, SPS_OP_LINE, 7'h28, 8'h00, 0, 5);
      put(2, SPS_OP_LINE, 7'h20, 8'h00, 9, 6);
      put(6, SPS_OP_CALL, 7'h00, 8'h00, 20, 0);
      put(20, SPS_OP_SWITCH, 7'h01, 8'h37, 22, 0);
      put(22, SPS_OP_SWITCH, 7'h06, 8'h08, 0, 30);
      put(23, SPS_OP_SWITCH, 7'h05, 8'hC8, 40, 24);
      put(24, SPS_OP_CALL, 7'h00, 8'h00, 28, 0);
      put(28, SPS_OP_MOTION, 7'h00, 8'h00, 0, 0);
      put(29, SPS_OP_WAITM, 7'h00, 8'h00, 0, 0);
      put(30, SPS_OP_RET, 7'h00, 8'h00, 0, 0);
      put(25, SPS_OP_RET, 7'h00, 8'h00, 0, 0);
      put(26, SPS_OP_END, 7'h00, 8'h00, 0, 0);
      put(40, SPS_OP_MOTION, 7'h00, 8'h00, 0, 0);
      put(41, SPS_OP_WAITM, 7'h00, 8'h00, 0, 0);
      for (int r = 0; r < 2; r++) begin
         far.lat = r * 3;
         exp_fa = '{1, 2, 6, 20, 22, 23, 24, 28, 29, 30, 25, 26};
         exp_ma.push_back(16'h001C);
         send(SPS_CMD_RUN, 16'h0001, 1'b1);
         idle();
         check(nest_err, 1'b1);
         check(in_sub, 1'b0);
         check(16'(exp_fa.size()), 16'h0000);
      end
      // Abort during a long motion, while the motion-wait instruction is still being fetched; a run offered meanwhile is refused
      far.mot_len = 250;
      exp_fa = '{40, 41};
      exp_ma.push_back(16'h0028);
      send(SPS_CMD_RUN, 16'h0028, 1'b1);
      repeat (10) @(negedge clk_sys);
      send(SPS_CMD_RUN, 16'h0001, 1'b0);
      for (int k = 0; k < 2; k++) begin
         send(SPS_CMD_ABORT, 16'h0000, 1'b0);
         @(negedge clk_sys);
         check(motor_stop, 1'b1);
         check(running, 1'b0);
      end
      idle();
      check(16'(exp_fa.size()), 16'h0000);
      check(16'(exp_ma.size()), 16'h0000);
      end_of_test();
   end
endmodule : test_stored_program_flow_sequencer
`default_nettype wire
